// ===== sfvc_device.sv
module sfvc_device
#(
    parameter int ADDR_W = sfvc_pkg::ADDR_W
)
(
    sfvc_link_if.dev link,
    input wire logic reset,
    output logic [ADDR_W-1:0] rdAddr,
    input wire logic [7:0] rdData,
    output logic [3:0] cfgDummyCode,
    output logic cfgExecuteInPlace,
    output logic [1:0] cfgWrap,
    output logic executeInPlaceActive
);

    // ********************************
    // State
    // ********************************
    typedef enum logic [2:0]
    {
        PH_CMD = 3'b000,
        PH_ADDR = 3'b001,
        PH_DUMMY = 3'b010,
        PH_OUT = 3'b011,
        PH_IN = 3'b100,
        PH_SKIP = 3'b101
    } sfvc_dev_phase_t;

    typedef struct packed {
        sfvc_dev_phase_t phase;
        logic [4:0] cnt;
        logic [7:0] shiftIn;
        logic [7:0] shiftOut;
        logic [ADDR_W-1:0] addr;
        logic [3:0] dummyLeft;
        logic srcVcr;
        logic wrPend;
        logic inPlace;
        logic [7:0] vcr;
        logic [7:0] icr;
        logic miso;
    } sfvc_dev_state_t;

    localparam sfvc_dev_state_t RESET_STATE = '{
        phase: PH_CMD,
        cnt: 5'h00,
        shiftIn: 8'h00,
        shiftOut: 8'h00,
        addr: '0,
        dummyLeft: 4'h0,
        srcVcr: 1'b0,
        wrPend: 1'b0,
        inPlace: 1'b0,
        vcr: sfvc_pkg::VCR_RESET,
        icr: sfvc_pkg::VCR_RESET,
        miso: 1'b0
    };

    localparam logic [4:0] LAST_BIT = 5'h07;
    localparam logic [4:0] LAST_ADDR_BIT = 5'(ADDR_W - 1);

    sfvc_dev_state_t q;
    sfvc_dev_state_t d;

    // ********************************
    // Helpers
    // ********************************
    function automatic logic [3:0] dummyCycles(input logic [7:0] cfg);
        logic [3:0] code;
        code = cfg[sfvc_pkg::DUMMY_HI:sfvc_pkg::DUMMY_LO];
        if (code == sfvc_pkg::DUMMY_ZERO || code == sfvc_pkg::DUMMY_DEFAULT)
        begin
            return sfvc_pkg::FAST_READ_DUMMY;
        end
        return code;
    endfunction

    function automatic logic [ADDR_W-1:0] nextAddr(input logic [ADDR_W-1:0] a,
                                                   input logic [1:0] wrap);
        logic [ADDR_W-1:0] mask;
        logic [ADDR_W-1:0] inc;
        mask = '0;
        inc = a + 1'b1;
        unique case (wrap)
            sfvc_pkg::WRAP_16: mask[5:0] = sfvc_pkg::MASK_16;
            sfvc_pkg::WRAP_32: mask[5:0] = sfvc_pkg::MASK_32;
            sfvc_pkg::WRAP_64: mask[5:0] = sfvc_pkg::MASK_64;
            sfvc_pkg::WRAP_CONT: mask = '1;
        endcase
        return (a & ~mask) | (inc & mask);
    endfunction

    // ********************************
    // Next state
    // ********************************
    // The host launches csN and mosi on falling link edges, so both are
    // already in this domain and are sampled here without synchronisers.
    always_comb
    begin
        logic [7:0] opcode;
        logic [7:0] nextByte;
        d = q;
        opcode = {q.shiftIn[6:0], link.mosi};
        nextByte = q.srcVcr ? q.vcr : rdData;
        if (link.csN)
        begin
            d.phase = q.inPlace ? PH_ADDR : PH_CMD;
            d.cnt = 5'h00;
            d.miso = 1'b0;
            if (q.wrPend)
            begin
                d.vcr = q.shiftIn & ~sfvc_pkg::RSVD_MASK;
                d.icr = q.shiftIn & ~sfvc_pkg::RSVD_MASK;
                d.wrPend = 1'b0;
            end
            d.inPlace = q.inPlace && !d.icr[sfvc_pkg::EXEC_BIT];
        end
        else
        begin
            unique case (q.phase)
                PH_CMD:
                begin
                    d.shiftIn = opcode;
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == LAST_BIT)
                    begin
                        d.cnt = 5'h00;
                        if (opcode == sfvc_pkg::OP_READ_VCR)
                        begin
                            d.icr = q.vcr;
                            d.srcVcr = 1'b1;
                            d.phase = PH_OUT;
                            d.miso = q.vcr[7];
                            d.shiftOut = {q.vcr[6:0], 1'b0};
                        end
                        else if (opcode == sfvc_pkg::OP_WRITE_VCR)
                        begin
                            d.phase = PH_IN;
                        end
                        else if (opcode == sfvc_pkg::OP_FAST_READ)
                        begin
                            d.phase = PH_ADDR;
                        end
                        else
                        begin
                            d.phase = PH_SKIP;
                        end
                    end
                end
                PH_ADDR:
                begin
                    d.addr = {q.addr[ADDR_W-2:0], link.mosi};
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == LAST_ADDR_BIT)
                    begin
                        d.cnt = 5'h00;
                        d.phase = PH_DUMMY;
                        d.srcVcr = 1'b0;
                        d.dummyLeft = dummyCycles(q.icr) - 4'h1;
                        d.inPlace = !q.icr[sfvc_pkg::EXEC_BIT];
                    end
                end
                PH_DUMMY:
                begin
                    d.dummyLeft = q.dummyLeft - 4'h1;
                    if (q.dummyLeft == 4'h0)
                    begin
                        d.phase = PH_OUT;
                        d.miso = rdData[7];
                        d.shiftOut = {rdData[6:0], 1'b0};
                        d.addr = nextAddr(q.addr, q.icr[sfvc_pkg::WRAP_HI:sfvc_pkg::WRAP_LO]);
                    end
                end
                PH_OUT:
                begin
                    d.cnt = q.cnt + 5'h01;
                    d.miso = q.shiftOut[7];
                    d.shiftOut = {q.shiftOut[6:0], 1'b0};
                    if (q.cnt == LAST_BIT)
                    begin
                        d.cnt = 5'h00;
                        d.miso = nextByte[7];
                        d.shiftOut = {nextByte[6:0], 1'b0};
                        if (!q.srcVcr)
                        begin
                            d.addr = nextAddr(q.addr, q.icr[sfvc_pkg::WRAP_HI:sfvc_pkg::WRAP_LO]);
                        end
                    end
                end
                PH_IN:
                begin
                    d.shiftIn = opcode;
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == LAST_BIT)
                    begin
                        d.wrPend = 1'b1;
                        d.phase = PH_SKIP;
                    end
                end
                PH_SKIP:
                begin
                    d.miso = 1'b0;
                end
                default:
                begin
                    d.phase = PH_SKIP;
                end
            endcase
        end
        if (reset)
        begin
            d = RESET_STATE;
        end
    end

    always_ff @(posedge link.sclk)
    begin
        q <= d;
    end

    // ********************************
    // Outputs
    // ********************************
    assign link.miso = q.miso;
    assign rdAddr = q.addr;
    assign cfgDummyCode = q.icr[sfvc_pkg::DUMMY_HI:sfvc_pkg::DUMMY_LO];
    assign cfgExecuteInPlace = !q.icr[sfvc_pkg::EXEC_BIT];
    assign cfgWrap = q.icr[sfvc_pkg::WRAP_HI:sfvc_pkg::WRAP_LO];
    assign executeInPlaceActive = q.inPlace;

endmodule

// ===== sfvc_host.sv
// The APB slave port and the register offsets are this design's own decisions.
module sfvc_host
#(
    parameter int DIV = sfvc_pkg::CLK_DIV
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    sfvc_link_if.host link
);

    // ********************************
    // State
    // ********************************
    typedef enum logic [2:0]
    {
        HP_IDLE = 3'b000,
        HP_OPC = 3'b001,
        HP_ADDR = 3'b010,
        HP_DUMMY = 3'b011,
        HP_DATA = 3'b100,
        HP_FINISH = 3'b101
    } sfvc_host_phase_t;

    typedef struct packed {
        sfvc_host_phase_t phase;
        logic [7:0] divCnt;
        logic sclk;
        logic csN;
        logic [31:0] txShift;
        logic fresh;
        logic [4:0] cnt;
        logic [7:0] bytesLeft;
        logic [3:0] dummyLeft;
        logic [7:0] opc;
        logic [7:0] nbytes;
        logic [3:0] dummy;
        logic skipCmd;
        logic txMode;
        logic [23:0] addr;
        logic sendAddr;
        logic [7:0] txData;
        logic [31:0] rx;
        logic busy;
        logic done;
        logic go;
        logic [31:0] prdata;
        logic misoMeta;
        logic misoSync;
    } sfvc_host_state_t;

    localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
    // Link clock is sys_clk / (2 * DIV), far below every single rate limit.
    localparam int LINK_MHZ = sfvc_pkg::SYS_CLK_MHZ / (2 * DIV);

    sfvc_host_state_t q;
    sfvc_host_state_t d;

    // ********************************
    // Helpers
    // ********************************
    function automatic sfvc_host_phase_t segAfter(input sfvc_host_phase_t ph,
                                                 input sfvc_host_state_t s);
        if (ph < HP_ADDR && s.sendAddr)
        begin
            return HP_ADDR;
        end
        if (ph < HP_DUMMY && s.dummy != 4'h0)
        begin
            return HP_DUMMY;
        end
        if (ph < HP_DATA && s.nbytes != 8'h00)
        begin
            return HP_DATA;
        end
        return HP_FINISH;
    endfunction

    function automatic logic [31:0] segData(input sfvc_host_phase_t ph,
                                            input sfvc_host_state_t s);
        logic [7:0] txByte;
        txByte = s.txData;
        if (s.opc == sfvc_pkg::OP_WRITE_VCR)
        begin
            txByte = s.txData & ~sfvc_pkg::RSVD_MASK;
        end
        unique case (ph)
            HP_OPC: return {s.opc, 24'h000000};
            HP_ADDR: return {s.addr, 8'h00};
            HP_DATA: return s.txMode ? {txByte, 24'h000000} : 32'h00000000;
            default: return 32'h00000000;
        endcase
    endfunction

    // ********************************
    // Next state
    // ********************************
    always_comb
    begin
        logic tick;
        logic rise;
        logic fall;
        logic access;
        d = q;
        access = psel && penable;
        d.misoMeta = link.miso;
        d.misoSync = q.misoMeta;
        if (psel && !penable)
        begin
            unique case (paddr)
                sfvc_pkg::REG_CMD: d.prdata = {10'h000, q.txMode, q.skipCmd, q.dummy,
                                               q.nbytes, q.opc};
                sfvc_pkg::REG_ADDR: d.prdata = {7'h00, q.sendAddr, q.addr};
                sfvc_pkg::REG_TXDATA: d.prdata = {24'h000000, q.txData};
                sfvc_pkg::REG_RXDATA: d.prdata = q.rx;
                sfvc_pkg::REG_STATUS: d.prdata = {30'h00000000, q.done, q.busy};
                default: d.prdata = 32'h00000000;
            endcase
        end
        if (access && pwrite)
        begin
            if (paddr == sfvc_pkg::REG_CMD && !q.busy)
            begin
                d.opc = pwdata[7:0];
                d.nbytes = pwdata[sfvc_pkg::CMD_NBYTES_LO +: 8];
                d.dummy = pwdata[sfvc_pkg::CMD_DUMMY_LO +: 4];
                d.skipCmd = pwdata[sfvc_pkg::CMD_SKIP_BIT];
                d.txMode = pwdata[sfvc_pkg::CMD_TX_BIT];
                d.go = 1'b1;
                d.busy = 1'b1;
            end
            if (paddr == sfvc_pkg::REG_ADDR && !q.busy)
            begin
                d.addr = pwdata[23:0];
                d.sendAddr = pwdata[sfvc_pkg::ADDR_SEND_BIT];
            end
            if (paddr == sfvc_pkg::REG_TXDATA && !q.busy)
            begin
                d.txData = pwdata[7:0];
            end
            if (paddr == sfvc_pkg::REG_STATUS && pwdata[sfvc_pkg::STAT_DONE_BIT])
            begin
                d.done = 1'b0;
            end
        end
        tick = (q.divCnt == DIV_LAST);
        d.divCnt = tick ? 8'h00 : q.divCnt + 8'h01;
        rise = tick && !q.sclk;
        fall = tick && q.sclk;
        if (tick)
        begin
            d.sclk = !q.sclk;
        end
        if (rise)
        begin
            unique case (q.phase)
                HP_OPC, HP_ADDR:
                begin
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == ((q.phase == HP_OPC) ? 5'h07 : 5'h17))
                    begin
                        d.cnt = 5'h00;
                        d.phase = segAfter(q.phase, q);
                        d.fresh = 1'b1;
                    end
                end
                HP_DUMMY:
                begin
                    d.dummyLeft = q.dummyLeft - 4'h1;
                    if (q.dummyLeft == 4'h0)
                    begin
                        d.phase = segAfter(q.phase, q);
                        d.fresh = 1'b1;
                    end
                end
                HP_DATA:
                begin
                    d.rx = {q.rx[30:0], q.misoSync};
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == 5'h07)
                    begin
                        d.cnt = 5'h00;
                        d.fresh = 1'b1;
                        d.bytesLeft = q.bytesLeft - 8'h01;
                        if (q.bytesLeft == 8'h01)
                        begin
                            d.phase = HP_FINISH;
                        end
                    end
                end
                default:
                begin
                    d.cnt = q.cnt;
                end
            endcase
        end
        if (fall)
        begin
            if (q.phase == HP_FINISH)
            begin
                d.csN = 1'b1;
                d.phase = HP_IDLE;
                d.busy = 1'b0;
                d.done = 1'b1;
            end
            else if (q.phase == HP_IDLE && q.go)
            begin
                d.go = 1'b0;
                d.csN = 1'b0;
                d.cnt = 5'h00;
                d.fresh = 1'b0;
                d.dummyLeft = q.dummy - 4'h1;
                d.bytesLeft = q.nbytes;
                d.phase = q.skipCmd ? segAfter(HP_OPC, q) : HP_OPC;
                d.txShift = segData(d.phase, q);
            end
            else if (q.phase != HP_IDLE)
            begin
                d.fresh = 1'b0;
                d.txShift = q.fresh ? segData(q.phase, q) : {q.txShift[30:0], 1'b0};
            end
        end
        if (reset)
        begin
            d = '0;
            d.csN = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        q <= d;
    end

    // ********************************
    // Outputs
    // ********************************
    assign link.sclk = q.sclk;
    assign link.csN = q.csN;
    assign link.mosi = q.txShift[31];
    assign prdata = q.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && paddr != sfvc_pkg::REG_CMD
        && paddr != sfvc_pkg::REG_ADDR && paddr != sfvc_pkg::REG_TXDATA
        && paddr != sfvc_pkg::REG_RXDATA && paddr != sfvc_pkg::REG_STATUS;

endmodule

// ===== sfvc_link_assertions.sv
// ********************************
// Link checks on the device side
// ********************************
module sfvc_link_assertions
(
    input wire logic sclk,
    input wire logic csN,
    input wire logic mosi,
    input wire logic reset,
    input wire logic [3:0] cfgDummyCode,
    input wire logic cfgExecuteInPlace,
    input wire logic [1:0] cfgWrap,
    input wire logic executeInPlaceActive
);
    logic [5:0] cntQ;
    logic [7:0] shQ;
    logic [7:0] opQ;
    logic [7:0] byteQ;

    // The count saturates so that long read frames never alias a short write.
    always_ff @(posedge sclk)
    begin
        cntQ <= (reset || csN) ? 6'h00 : cntQ + {5'h0, cntQ != 6'h3f};
        shQ <= {shQ[6:0], mosi};
        opQ <= (!csN && cntQ == 6'h07) ? {shQ[6:0], mosi} : opQ;
        byteQ <= csN ? shQ : byteQ;
    end

    default clocking cb @(posedge sclk); endclocking
    default disable iff (reset);

    sequence s_write_end;
        csN && cntQ == 6'h10 && opQ == sfvc_pkg::OP_WRITE_VCR;
    endsequence
    sequence s_read_end;
        csN && cntQ >= 6'h10 && opQ == sfvc_pkg::OP_READ_VCR;
    endsequence

    a_write_applies: assert property (s_write_end |=>
        cfgDummyCode == byteQ[7:4] && cfgWrap == byteQ[1:0] && cfgExecuteInPlace == !byteQ[3])
        else $error("Config does not follow the written byte.");
    a_read_keeps: assert property (s_read_end |=> $stable(cfgDummyCode)
        && $stable(cfgWrap) && $stable(cfgExecuteInPlace))
        else $error("Config changed by a register read.");
    a_frame_stable: assert property ((!csN && !$past(csN)) |->
        $stable(cfgDummyCode) && $stable(cfgWrap) && $stable(cfgExecuteInPlace))
        else $error("Config changed inside a frame.");
    a_change_idle: assert property (($changed(cfgDummyCode) || $changed(cfgWrap)) |-> $past(csN))
        else $error("Config changed while selected.");
    a_reset_defaults: assert property ($fell(reset) |-> cfgDummyCode == 4'hf
        && cfgWrap == 2'b11 && !cfgExecuteInPlace && !executeInPlaceActive)
        else $error("Config not at defaults after reset.");
    a_in_place_enter: assert property ($rose(executeInPlaceActive) |->
        cfgExecuteInPlace)
        else $error("Execute in place entered while disabled.");
    a_in_place_exit: assert property ($fell(cfgExecuteInPlace) |->
        ##[0:2] !executeInPlaceActive)
        else $error("Execute in place kept after disable.");
    a_in_place_frame: assert property (($fell(csN) && executeInPlaceActive) |->
        cfgExecuteInPlace)
        else $error("Frame without opcode while disabled.");
endmodule

// ===== sfvc_link_if.sv
interface sfvc_link_if;
    logic sclk;
    logic csN;
    logic mosi;
    logic miso;

    modport host
    (
        output sclk,
        output csN,
        output mosi,
        input miso
    );

    modport dev
    (
        input sclk,
        input csN,
        input mosi,
        output miso
    );
endinterface

// ===== sfvc_pkg.sv
package sfvc_pkg;

    // ********************************
    // Link commands
    // ********************************
    localparam logic [7:0] OP_READ_VCR = 8'h85;
    localparam logic [7:0] OP_WRITE_VCR = 8'h81;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam int ADDR_W = 24;
    localparam int BYTE_W = 8;

    // ********************************
    // Volatile configuration layout
    // ********************************
    localparam int DUMMY_HI = 7;
    localparam int DUMMY_LO = 4;
    localparam int EXEC_BIT = 3;
    localparam int RSVD_BIT = 2;
    localparam int WRAP_HI = 1;
    localparam int WRAP_LO = 0;
    localparam logic [7:0] VCR_RESET = 8'hfb;
    localparam logic [7:0] RSVD_MASK = 8'h04;
    localparam logic [3:0] DUMMY_ZERO = 4'h0;
    localparam logic [3:0] DUMMY_DEFAULT = 4'hf;
    localparam logic [3:0] FAST_READ_DUMMY = 4'h8;
    localparam logic [1:0] WRAP_16 = 2'b00;
    localparam logic [1:0] WRAP_32 = 2'b01;
    localparam logic [1:0] WRAP_64 = 2'b10;
    localparam logic [1:0] WRAP_CONT = 2'b11;
    localparam logic [5:0] MASK_16 = 6'h0f;
    localparam logic [5:0] MASK_32 = 6'h1f;
    localparam logic [5:0] MASK_64 = 6'h3f;

    // ********************************
    // Link clock limits
    // ********************************
    localparam int SYS_CLK_MHZ = 20;
    localparam int CLK_DIV = 2;
    localparam int SINGLE_RATE_FAST_READ_MHZ = 94;
    localparam int SINGLE_RATE_QUAD_IO_MHZ = 133;
    localparam int SINGLE_RATE_QUAD_IO_MIN_DUMMY = 11;
    localparam int UT_QUAD_MHZ = 108;

    // ********************************
    // Controller registers
    // ********************************
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_TXDATA = 8'h08;
    localparam logic [7:0] REG_RXDATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CMD_NBYTES_LO = 8;
    localparam int CMD_DUMMY_LO = 16;
    localparam int CMD_SKIP_BIT = 20;
    localparam int CMD_TX_BIT = 21;
    localparam int ADDR_SEND_BIT = 24;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;

endpackage

// ===== testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic devReset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [23:0] rdAddr;
    logic [7:0] rdData;
    logic [3:0] cfgDummyCode;
    logic cfgExecuteInPlace;
    logic [1:0] cfgWrap;
    logic executeInPlaceActive;
    logic [31:0] rdQ;
    logic errQ;
    logic [7:0] vals [4] = '{8'h13, 8'he5, 8'h0e, 8'hfb};
    logic [7:0] wcfg [6] = '{8'h28, 8'h29, 8'h2a, 8'h2b, 8'h0b, 8'hfb};
    int wdum [6] = '{2, 2, 2, 2, 8, 8};
    int fails = 0;
    int samplesChecked = 0;

    sfvc_link_if link();
    // Memory contents are a fixed pattern of the address.
    assign rdData = rdAddr[7:0] ^ 8'h5a;

    sfvc_host i_sfvc_host (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link.host));
    sfvc_device i_sfvc_device (.link(link.dev), .reset(devReset), .rdAddr(rdAddr),
        .rdData(rdData), .cfgDummyCode(cfgDummyCode), .cfgExecuteInPlace(cfgExecuteInPlace),
        .cfgWrap(cfgWrap), .executeInPlaceActive(executeInPlaceActive));
    sfvc_link_assertions i_sfvc_link_assertions (.sclk(link.sclk), .csN(link.csN),
        .mosi(link.mosi), .reset(devReset), .cfgDummyCode(cfgDummyCode),
        .cfgExecuteInPlace(cfgExecuteInPlace), .cfgWrap(cfgWrap),
        .executeInPlaceActive(executeInPlaceActive));

    initial forever #25 sys_clk = ~sys_clk;

    // ********************************
    // Bus cycles, frames and checks
    // ********************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samplesChecked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdQ = prdata;
        errQ = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] cmdw(logic [7:0] op, int n, int dum, logic skip, logic tx);
        return {10'h0, tx, skip, dum[3:0], n[7:0], op};
    endfunction

    // Polling is bounded so a frame that never ends shows up as a mismatch.
    task automatic frame(input logic [31:0] cmd, input logic [23:0] adr, input logic [7:0] tx);
        // Only a memory read carries an address after its opcode.
        apb(1'b1, sfvc_pkg::REG_ADDR, {7'h00, cmd[7:0] == sfvc_pkg::OP_FAST_READ, adr});
        apb(1'b1, sfvc_pkg::REG_TXDATA, {24'h0, tx});
        apb(1'b1, sfvc_pkg::REG_CMD, cmd);
        rdQ = 32'h0;
        for (int i = 0; i < 400 && rdQ[1] !== 1'b1; i++)
            apb(1'b0, sfvc_pkg::REG_STATUS, 32'h0);
        check({31'h0, rdQ[1]}, 32'h1, "frame done");
        apb(1'b1, sfvc_pkg::REG_STATUS, 32'h2);
        apb(1'b0, sfvc_pkg::REG_RXDATA, 32'h0);
    endtask

    task automatic write_cfg(input logic [7:0] v);
        frame(cmdw(sfvc_pkg::OP_WRITE_VCR, 1, 0, 1'b0, 1'b1), 24'h0, v);
    endtask

    function automatic logic [31:0] cfg_now();
        return {23'h0, executeInPlaceActive, cfgDummyCode, ~cfgExecuteInPlace, 1'b0, cfgWrap};
    endfunction

    function automatic logic [31:0] expect4(input logic [23:0] a, input logic [1:0] w);
        logic [23:0] m;
        logic [31:0] e;
        m = (w == 2'b00) ? 24'h0f : (w == 2'b01) ? 24'h1f : (w == 2'b10) ? 24'h3f : 24'hffffff;
        e = 32'h0;
        for (int i = 0; i < 4; i++)
        begin
            e = {e[23:0], a[7:0] ^ 8'h5a};
            a = (a & ~m) | ((a + 24'h1) & m);
        end
        return e;
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        fails++;
        $display("wrong value at %0t: watchdog expired", $time);
        print_verdict();
    end

    // The link clock only runs once the host is out of reset.
    initial
    begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (20) @(posedge sys_clk);
        @(posedge link.sclk);
        devReset <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check(cfg_now(), 32'hfb, "reset config");
        $display("test reset defaults done");
        foreach (vals[k])
        begin
            write_cfg(vals[k]);
            check(cfg_now(), {24'h0, vals[k] & 8'hfb}, "config");
            frame(cmdw(sfvc_pkg::OP_READ_VCR, 1, 0, 1'b0, 1'b0), 24'h0, 8'h00);
            check(rdQ & 32'hff, {24'h0, vals[k] & 8'hfb}, "readback");
        end
        $display("test register access done");
        foreach (wcfg[k])
        begin
            write_cfg(wcfg[k]);
            frame(cmdw(sfvc_pkg::OP_FAST_READ, 4, wdum[k], 1'b0, 1'b0), 24'h00123e, 8'h00);
            check(rdQ, expect4(24'h00123e, wcfg[k][1:0]), "read");
        end
        $display("test wrap and dummy done");
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, errQ}, 32'h1, "unmapped");
        $display("test unmapped done");
        write_cfg(8'h23);
        frame(cmdw(sfvc_pkg::OP_FAST_READ, 4, 2, 1'b0, 1'b0), 24'h000100, 8'h00);
        check(rdQ, expect4(24'h000100, 2'b11), "first read");
        check(cfg_now(), 32'h123, "in place on");
        frame(cmdw(sfvc_pkg::OP_FAST_READ, 4, 2, 1'b1, 1'b0), 24'h000200, 8'h00);
        check(rdQ, expect4(24'h000200, 2'b11), "in place read");
        @(posedge link.sclk);
        devReset <= 1'b1;
        repeat (20) @(posedge sys_clk);
        @(posedge link.sclk);
        devReset <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check(cfg_now(), 32'hfb, "second reset");
        $display("test execute in place done");
        print_verdict();
    end
endmodule
